/* hdl/ccsr_pkg.sv */
package ccsr_pkg;
    // direct-space offsets
    localparam logic [7:0] OFS_POWER_CONTROL = 8'h87;
    localparam logic [7:0] OFS_MEMORY_CONFIG = 8'haf;
    localparam logic [7:0] OFS_STACK_TOP_HIGH = 8'hb7;
    localparam logic [7:0] OFS_STATUS_WORD = 8'hd0;
    localparam logic [7:0] OFS_STACK_TOP_LOW = 8'h81;
    localparam logic [7:0] OFS_DATA_PTR_LOW = 8'h82;
    localparam logic [7:0] OFS_DATA_PTR_HIGH = 8'h83;
    localparam logic [7:0] OFS_DATA_PTR_PAGE = 8'h84;
    localparam logic [7:0] OFS_MATH_RESULT = 8'he0;
    localparam logic [7:0] OFS_AUX_MATH = 8'hf0;
    // the register space is the upper 128 bytes: address bit 7 set
    localparam int SFR_SPACE_BIT = 7;

    // reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_STACK_TOP_LOW = 8'h07;

    // status word fields
    localparam int ST_CARRY = 7;
    localparam int ST_AUX_CARRY = 6;
    localparam int ST_USER_ZERO = 5;
    localparam int ST_BANK_HI = 4;
    localparam int ST_BANK_LO = 3;
    localparam int ST_SIGNED = 2;
    localparam int ST_USER_ONE = 1;
    localparam int ST_PARITY = 0;

    // power control fields
    localparam int PC_BAUD_DOUBLE = 7;
    localparam int PC_SERIAL_WAKE = 6;
    localparam int PC_EXT0_WAKE = 5;
    localparam int PC_LATCH_OFF = 4;
    localparam int PC_SLEEP = 1;
    localparam int PC_HALT = 0;

    // memory config fields
    localparam int MC_WIDE_STACK = 7;
    localparam int MC_ONCHIP_RAM = 0;
    localparam logic [7:0] MC_WRITE_MASK = 8'h81;

    // stack
    localparam int STACK_AW = 11;
    localparam logic [7:0] STACK_HIGH_MASK = 8'h07;
    localparam logic [7:0] STACK_LOW_TOP = 8'hff;

    // external data space: 16 Mbytes, on-chip part is the lowest 2 Kbytes
    localparam int XDATA_AW = 24;
    localparam int ONCHIP_RAM_AW = 11;
    localparam int ONCHIP_RAM_BYTES = 2048;
    localparam logic [23:0] ONCHIP_RAM_TOP = 24'h0007ff;
    localparam int EXT_STROBE_CYCLES = 2;

    typedef enum logic [1:0] {
        XS_IDLE,
        XS_ONCHIP,
        XS_EXT
    } ccsr_xfer_state_t;
endpackage

/* hdl/ccsr_ram_if.sv */
`timescale 1ns/1ps
interface ccsr_ram_if #(
    parameter int AW = ccsr_pkg::ONCHIP_RAM_AW,
    parameter int DW = 8
);
    logic en;
    logic we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;

    modport ctrl (output en, output we, output addr, output wdata, input rdata);
    modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface

/* hdl/ccsr_onchip_ext_ram.sv */
`timescale 1ns/1ps
module ccsr_onchip_ext_ram #(
    parameter int DEPTH = ccsr_pkg::ONCHIP_RAM_BYTES,
    parameter int AW = ccsr_pkg::ONCHIP_RAM_AW,
    parameter int DW = 8
) (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    ccsr_ram_if.mem ram
);
    logic [DW-1:0] store [DEPTH];

    always_ff @(posedge i_sys_clk) begin
        if (ram.en && ram.we) begin
            store[ram.addr] <= ram.wdata;
        end
    end

    // registered read port
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ram.rdata <= '0;
        end else if (ram.en && !ram.we) begin
            ram.rdata <= store[ram.addr];
        end
    end
endmodule

/* hdl/ccsr_bank.sv */
`timescale 1ns/1ps
module ccsr_bank (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_direct,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    output logic o_sfr_hit,
    output logic [7:0] o_sfr_rdata,
    input wire logic i_status_bit_wr,
    input wire logic [2:0] i_status_bit_sel,
    input wire logic i_status_bit_val,
    input wire logic i_flags_wr,
    input wire logic i_carry_bit,
    input wire logic i_aux_carry,
    input wire logic i_signed_range_flag,
    input wire logic i_math_wr,
    input wire logic [7:0] i_math_wdata,
    input wire logic i_aux_wr,
    input wire logic [7:0] i_aux_wdata,
    output logic [7:0] o_math_result,
    output logic [7:0] o_aux_math,
    input wire logic i_data_pointer_inc,
    output logic [23:0] o_data_pointer,
    input wire logic i_stack_push,
    input wire logic i_stack_pop,
    output logic [10:0] o_stack_addr,
    output logic o_stack_wr,
    output logic o_stack_in_onchip_ext_ram,
    output logic [1:0] o_reg_bank,
    output logic o_baud_double,
    output logic o_serial_periph_wake_enable,
    output logic o_ext_int_zero_wake_enable,
    output logic o_latch_strobe_disable,
    output logic o_sleep_enable,
    output logic o_core_halt_enable,
    output logic o_wide_stack_enable,
    output logic o_onchip_ext_ram_enable,
    input wire logic i_xfer_req,
    input wire logic i_xfer_write,
    input wire logic [7:0] i_xfer_wdata,
    output logic o_xfer_busy,
    output logic o_xfer_done,
    output logic [7:0] o_xfer_rdata,
    output logic [23:0] o_ext_addr,
    output logic [7:0] o_ext_wdata,
    output logic o_ext_bus_oe,
    output logic o_ext_rd_n,
    output logic o_ext_wr_n,
    input wire logic [7:0] i_ext_rdata
);
    logic [7:0] power_control;
    logic [7:0] memory_config;
    logic [7:0] stack_top_high;
    logic [7:0] stack_top_low;
    logic [7:0] cpu_status_word;
    logic [7:0] math_result_reg;
    logic [7:0] aux_math_reg;
    logic [7:0] data_ptr_page;
    logic [7:0] data_ptr_high;
    logic [7:0] data_ptr_low;
    logic sfr_sel;
    logic wide;
    logic [10:0] sp_wide;
    logic [7:0] status_read;
    logic [7:0] next_rdata;
    logic onchip_hit;
    logic [2:0] strobe_cnt;
    ccsr_pkg::ccsr_xfer_state_t xstate;
    ccsr_ram_if ram ();

    ccsr_onchip_ext_ram u_onchip_ext_ram (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .ram(ram.mem)
    );

    // indirect cycles never decode here
    assign sfr_sel = i_sfr_direct && i_sfr_addr[ccsr_pkg::SFR_SPACE_BIT];
    wire wr_pc = i_sfr_wr && sfr_sel && i_sfr_addr == ccsr_pkg::OFS_POWER_CONTROL;
    wire wr_mc = i_sfr_wr && sfr_sel && i_sfr_addr == ccsr_pkg::OFS_MEMORY_CONFIG;
    wire wr_sph = i_sfr_wr && sfr_sel && i_sfr_addr == ccsr_pkg::OFS_STACK_TOP_HIGH;
    wire wr_spl = i_sfr_wr && sfr_sel && i_sfr_addr == ccsr_pkg::OFS_STACK_TOP_LOW;
    wire wr_st = i_sfr_wr && sfr_sel && i_sfr_addr == ccsr_pkg::OFS_STATUS_WORD;
    wire wr_dpl = i_sfr_wr && sfr_sel && i_sfr_addr == ccsr_pkg::OFS_DATA_PTR_LOW;
    wire wr_dph = i_sfr_wr && sfr_sel && i_sfr_addr == ccsr_pkg::OFS_DATA_PTR_HIGH;
    wire wr_dpp = i_sfr_wr && sfr_sel && i_sfr_addr == ccsr_pkg::OFS_DATA_PTR_PAGE;
    wire wr_acc = i_sfr_wr && sfr_sel && i_sfr_addr == ccsr_pkg::OFS_MATH_RESULT;
    wire wr_aux = i_sfr_wr && sfr_sel && i_sfr_addr == ccsr_pkg::OFS_AUX_MATH;

    assign wide = memory_config[ccsr_pkg::MC_WIDE_STACK];
    assign sp_wide = {stack_top_high[2:0], stack_top_low};
    assign status_read = {cpu_status_word[7:1], ^math_result_reg};

    // read decode
    always_comb begin
        o_sfr_hit = sfr_sel;
        next_rdata = ccsr_pkg::RST_ZERO;
        unique case (i_sfr_addr)
            ccsr_pkg::OFS_POWER_CONTROL: next_rdata = power_control;
            ccsr_pkg::OFS_MEMORY_CONFIG: next_rdata = memory_config;
            ccsr_pkg::OFS_STACK_TOP_HIGH: next_rdata = wide ? stack_top_high : 8'h00;
            ccsr_pkg::OFS_STACK_TOP_LOW: next_rdata = stack_top_low;
            ccsr_pkg::OFS_STATUS_WORD: next_rdata = status_read;
            ccsr_pkg::OFS_DATA_PTR_LOW: next_rdata = data_ptr_low;
            ccsr_pkg::OFS_DATA_PTR_HIGH: next_rdata = data_ptr_high;
            ccsr_pkg::OFS_DATA_PTR_PAGE: next_rdata = data_ptr_page;
            ccsr_pkg::OFS_MATH_RESULT: next_rdata = math_result_reg;
            ccsr_pkg::OFS_AUX_MATH: next_rdata = aux_math_reg;
            default: o_sfr_hit = 1'b0;
        endcase
        if (!sfr_sel) begin
            next_rdata = ccsr_pkg::RST_ZERO;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_sfr_rdata <= ccsr_pkg::RST_ZERO;
        end else if (i_sfr_rd) begin
            o_sfr_rdata <= next_rdata;
        end
    end

    // power control and memory config
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            power_control <= ccsr_pkg::RST_ZERO;
            memory_config <= ccsr_pkg::RST_ZERO;
        end else begin
            if (wr_pc) begin
                power_control <= i_sfr_wdata;
            end
            if (wr_mc) begin
                memory_config <= i_sfr_wdata & ccsr_pkg::MC_WRITE_MASK;
            end
        end
    end

    // stack pointer: pre-increment on push, post-decrement on pop
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            stack_top_low <= ccsr_pkg::RST_STACK_TOP_LOW;
            stack_top_high <= ccsr_pkg::RST_ZERO;
        end else if (wr_spl || (wr_sph && wide)) begin
            if (wr_spl) begin
                stack_top_low <= i_sfr_wdata;
            end
            if (wr_sph && wide) begin
                stack_top_high <= i_sfr_wdata & ccsr_pkg::STACK_HIGH_MASK;
            end
        end else if (i_stack_push) begin
            if (wide) begin
                {stack_top_high[2:0], stack_top_low} <= sp_wide + 11'h001;
            end else begin
                stack_top_low <= stack_top_low + 8'h01;
            end
        end else if (i_stack_pop) begin
            if (wide) begin
                {stack_top_high[2:0], stack_top_low} <= sp_wide - 11'h001;
            end else begin
                stack_top_low <= stack_top_low - 8'h01;
            end
        end
    end

    // write strobe rises on the same edge as the increment
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_stack_wr <= 1'b0;
        end else begin
            o_stack_wr <= i_stack_push && !wr_spl && !(wr_sph && wide);
        end
    end

    assign o_stack_addr = wide ? sp_wide : {3'b000, stack_top_low};
    assign o_stack_in_onchip_ext_ram = wide && (stack_top_high[2:0] != 3'b000);

    // status word: byte write, then bit write, then alu flags
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cpu_status_word <= ccsr_pkg::RST_ZERO;
        end else if (wr_st) begin
            cpu_status_word <= i_sfr_wdata;
        end else if (i_status_bit_wr) begin
            cpu_status_word[i_status_bit_sel] <= i_status_bit_val;
        end else if (i_flags_wr) begin
            cpu_status_word[ccsr_pkg::ST_CARRY] <= i_carry_bit;
            cpu_status_word[ccsr_pkg::ST_AUX_CARRY] <= i_aux_carry;
            cpu_status_word[ccsr_pkg::ST_SIGNED] <= i_signed_range_flag;
        end
    end

    assign o_reg_bank = {cpu_status_word[ccsr_pkg::ST_BANK_HI],
                         cpu_status_word[ccsr_pkg::ST_BANK_LO]};

    // math registers: direct write wins over the execution unit port
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            math_result_reg <= ccsr_pkg::RST_ZERO;
            aux_math_reg <= ccsr_pkg::RST_ZERO;
        end else begin
            if (wr_acc) begin
                math_result_reg <= i_sfr_wdata;
            end else if (i_math_wr) begin
                math_result_reg <= i_math_wdata;
            end
            if (wr_aux) begin
                aux_math_reg <= i_sfr_wdata;
            end else if (i_aux_wr) begin
                aux_math_reg <= i_aux_wdata;
            end
        end
    end

    assign o_math_result = math_result_reg;
    assign o_aux_math = aux_math_reg;

    // data pointer: 16-bit increment carries into the page byte
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            data_ptr_page <= ccsr_pkg::RST_ZERO;
            data_ptr_high <= ccsr_pkg::RST_ZERO;
            data_ptr_low <= ccsr_pkg::RST_ZERO;
        end else if (wr_dpl || wr_dph || wr_dpp) begin
            if (wr_dpl) begin
                data_ptr_low <= i_sfr_wdata;
            end
            if (wr_dph) begin
                data_ptr_high <= i_sfr_wdata;
            end
            if (wr_dpp) begin
                data_ptr_page <= i_sfr_wdata;
            end
        end else if (i_data_pointer_inc) begin
            {data_ptr_page, data_ptr_high, data_ptr_low} <= o_data_pointer + 24'h000001;
        end
    end

    assign o_data_pointer = {data_ptr_page, data_ptr_high, data_ptr_low};
    assign onchip_hit = memory_config[ccsr_pkg::MC_ONCHIP_RAM]
                        && (o_data_pointer <= ccsr_pkg::ONCHIP_RAM_TOP);

    // on-chip RAM port, used only in the request cycle
    assign ram.en = (xstate == ccsr_pkg::XS_IDLE) && i_xfer_req && onchip_hit;
    assign ram.we = i_xfer_write;
    assign ram.addr = o_data_pointer[ccsr_pkg::ONCHIP_RAM_AW-1:0];
    assign ram.wdata = i_xfer_wdata;
    assign o_xfer_busy = (xstate != ccsr_pkg::XS_IDLE);

    // external data move sequencer
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            xstate <= ccsr_pkg::XS_IDLE;
            strobe_cnt <= '0;
            o_xfer_done <= 1'b0;
            o_xfer_rdata <= ccsr_pkg::RST_ZERO;
            o_ext_addr <= '0;
            o_ext_wdata <= ccsr_pkg::RST_ZERO;
            o_ext_bus_oe <= 1'b0;
            o_ext_rd_n <= 1'b1;
            o_ext_wr_n <= 1'b1;
        end else begin
            o_xfer_done <= 1'b0;
            unique case (xstate)
                ccsr_pkg::XS_IDLE: begin
                    if (i_xfer_req && onchip_hit) begin
                        xstate <= ccsr_pkg::XS_ONCHIP;
                    end else if (i_xfer_req) begin
                        xstate <= ccsr_pkg::XS_EXT;
                        strobe_cnt <= '0;
                        o_ext_addr <= o_data_pointer;
                        o_ext_wdata <= i_xfer_wdata;
                        o_ext_bus_oe <= 1'b1;
                        o_ext_rd_n <= i_xfer_write;
                        o_ext_wr_n <= !i_xfer_write;
                    end
                end
                ccsr_pkg::XS_ONCHIP: begin
                    o_xfer_rdata <= ram.rdata;
                    o_xfer_done <= 1'b1;
                    xstate <= ccsr_pkg::XS_IDLE;
                end
                ccsr_pkg::XS_EXT: begin
                    strobe_cnt <= strobe_cnt + 3'h1;
                    if (strobe_cnt == 3'(ccsr_pkg::EXT_STROBE_CYCLES - 1)) begin
                        if (!o_ext_rd_n) begin
                            o_xfer_rdata <= i_ext_rdata;
                        end
                        o_ext_bus_oe <= 1'b0;
                        o_ext_rd_n <= 1'b1;
                        o_ext_wr_n <= 1'b1;
                        o_xfer_done <= 1'b1;
                        xstate <= ccsr_pkg::XS_IDLE;
                    end
                end
            endcase
        end
    end

    assign o_baud_double = power_control[ccsr_pkg::PC_BAUD_DOUBLE];
    assign o_serial_periph_wake_enable = power_control[ccsr_pkg::PC_SERIAL_WAKE];
    assign o_ext_int_zero_wake_enable = power_control[ccsr_pkg::PC_EXT0_WAKE];
    assign o_latch_strobe_disable = power_control[ccsr_pkg::PC_LATCH_OFF];
    assign o_sleep_enable = power_control[ccsr_pkg::PC_SLEEP];
    assign o_core_halt_enable = power_control[ccsr_pkg::PC_HALT];
    assign o_wide_stack_enable = wide;
    assign o_onchip_ext_ram_enable = memory_config[ccsr_pkg::MC_ONCHIP_RAM];

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);

    wire sp_wr_any = wr_spl || wr_sph;
    chk_sp_reset_value: assert property ($rose(i_rstn)
        |-> stack_top_low == ccsr_pkg::RST_STACK_TOP_LOW)
        else $error("stack low not 07 after reset");
    chk_push_pre_inc: assert property (i_stack_push && !sp_wr_any && wide && !wr_mc
        |=> o_stack_addr == $past(o_stack_addr) + 11'h001 ##0 o_stack_wr)
        else $error("push did not increment before write");
    chk_narrow_wrap: assert property (i_stack_push && !sp_wr_any && !wide && !wr_mc
        && stack_top_low == 8'hff |=> o_stack_addr == 11'h000)
        else $error("narrow stack did not wrap to zero");
    chk_wide_roll: assert property (i_stack_push && !sp_wr_any && wide && !wr_mc
        && o_stack_addr == 11'h0ff |=> o_stack_addr == 11'h100 && o_stack_in_onchip_ext_ram)
        else $error("wide stack did not roll to 0100");
    chk_data_pointer_carry: assert property (i_data_pointer_inc && !wr_dpl && !wr_dph && !wr_dpp
        && {data_ptr_high, data_ptr_low} == 16'hffff
        |=> data_ptr_page == $past(data_ptr_page) + 8'h01 && data_ptr_low == 8'h00)
        else $error("pointer carry lost");
    chk_onchip_quiet: assert property (xstate == ccsr_pkg::XS_ONCHIP
        |-> !o_ext_bus_oe && o_ext_rd_n && o_ext_wr_n)
        else $error("pins driven during on-chip access");
    chk_far_goes_out: assert property (i_xfer_req && !o_xfer_busy
        && o_data_pointer > ccsr_pkg::ONCHIP_RAM_TOP
        |=> o_ext_bus_oe ##0 (o_ext_rd_n != o_ext_wr_n))
        else $error("far address did not go external");
    chk_strobe_ends: assert property ($rose(o_ext_bus_oe) |-> ##[1:8] o_xfer_done)
        else $error("external move never completed");
    chk_indirect_blocked: assert property (i_sfr_wr && !i_sfr_direct
        |=> $stable(power_control) && $stable(memory_config))
        else $error("indirect cycle changed a register");
    chk_cfg_reserved: assert property (wr_mc
        |=> (memory_config & ~ccsr_pkg::MC_WRITE_MASK) == ccsr_pkg::RST_ZERO
        && memory_config == ($past(i_sfr_wdata) & ccsr_pkg::MC_WRITE_MASK))
        else $error("reserved config bits took a write");
    chk_bank_follow: assert property (wr_st |=> o_reg_bank == $past(i_sfr_wdata[4:3]))
        else $error("bank select not taken");
    chk_math_write: assert property (i_math_wr && !wr_acc
        |=> o_math_result == $past(i_math_wdata) && status_read[0] == ^o_math_result)
        else $error("math result not written");
    chk_power_write: assert property (wr_pc |=> o_sleep_enable == $past(i_sfr_wdata[1])
        && o_core_halt_enable == $past(i_sfr_wdata[0]))
        else $error("power control not written");

    cov_wide_roll: cover property (wide && i_stack_push && o_stack_addr == 11'h0ff);
    cov_onchip_move: cover property (xstate == ccsr_pkg::XS_ONCHIP ##1 o_xfer_done);
    cov_ext_read: cover property (!o_ext_rd_n ##[1:8] o_xfer_done);
    cov_page_carry: cover property (i_data_pointer_inc && {data_ptr_high, data_ptr_low} == 16'hffff);
endmodule

/* tb/ccsr_ext_mem.sv */
`timescale 1ns/1ps
module ccsr_ext_mem (
    input wire logic i_sys_clk,
    input wire logic [23:0] i_addr,
    input wire logic i_rd_n,
    input wire logic i_bus_oe,
    output logic [7:0] o_rdata
);
    logic [7:0] last = 8'h00;
    logic drive;
    // answers only while read strobe is low and the bus is driven
    assign drive = !i_rd_n && i_bus_oe;
    // released bus holds the last byte for one cycle, then toggles every cycle
    always @(posedge i_sys_clk) begin
        last <= drive ? (i_addr[7:0] ^ 8'h5a) : ~last;
    end
    assign o_rdata = drive ? (i_addr[7:0] ^ 8'h5a) : last;
endmodule

/* tb/test_ccsr_bank.sv */
`timescale 1ns/1ps
module test_ccsr_bank;
    logic i_sys_clk, i_rstn, i_sfr_direct, i_sfr_wr, i_sfr_rd, i_status_bit_wr, i_status_bit_val;
    logic i_flags_wr, i_carry_bit, i_aux_carry, i_signed_range_flag, i_math_wr, i_aux_wr;
    logic i_data_pointer_inc, i_stack_push, i_stack_pop, i_xfer_req, i_xfer_write;
    logic [7:0] i_sfr_addr, i_sfr_wdata, i_math_wdata, i_aux_wdata, i_xfer_wdata, i_ext_rdata;
    logic [2:0] i_status_bit_sel;
    logic o_sfr_hit, o_stack_wr, o_stack_in_onchip_ext_ram, o_baud_double, o_serial_periph_wake_enable;
    logic o_ext_int_zero_wake_enable, o_latch_strobe_disable, o_sleep_enable, o_core_halt_enable;
    logic o_wide_stack_enable, o_onchip_ext_ram_enable, o_xfer_busy, o_xfer_done, o_ext_bus_oe;
    logic o_ext_rd_n, o_ext_wr_n;
    logic [7:0] o_sfr_rdata, o_math_result, o_aux_math, o_xfer_rdata, o_ext_wdata;
    logic [23:0] o_data_pointer, o_ext_addr;
    logic [10:0] o_stack_addr;
    logic [1:0] o_reg_bank;
    int n_fail, num_checks;

    ccsr_bank u_dut (.*);
    ccsr_ext_mem u_mem (.i_sys_clk(i_sys_clk), .i_addr(o_ext_addr), .i_rd_n(o_ext_rd_n),
        .i_bus_oe(o_ext_bus_oe), .o_rdata(i_ext_rdata));

    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic pulse(ref logic s);
        @(negedge i_sys_clk);
        s = 1'b1;
        @(negedge i_sys_clk);
        s = 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_sfr_addr = a;
        i_sfr_wdata = d;
        pulse(i_sfr_wr);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        i_sfr_addr = a;
        pulse(i_sfr_rd);
        chk("sfr_rdata", {16'h0, e}, {16'h0, o_sfr_rdata});
    endtask

    task automatic push(input logic [10:0] e);
        int k;
        pulse(i_stack_push);
        for (k = 0; k < 4 && o_stack_wr !== 1'b1; k++) @(negedge i_sys_clk);
        chk("stack_wr", 24'h1, {23'h0, o_stack_wr});
        chk("stack_addr", {13'h0, e}, {13'h0, o_stack_addr});
    endtask

    task automatic xfer(input logic w, input logic [7:0] d, input logic [7:0] e,
        input logic oe_exp, input logic [23:0] ea);
        int k;
        logic oe;
        oe = 1'b0;
        i_xfer_write = w;
        i_xfer_wdata = d;
        pulse(i_xfer_req);
        for (k = 0; k < 8 && o_xfer_done !== 1'b1; k++) begin
            chk("xfer_busy", 24'h1, {23'h0, o_xfer_busy});
            if (o_ext_bus_oe === 1'b1) begin
                oe = 1'b1;
                chk("ext_addr", ea, o_ext_addr);
                chk("ext_strobes", {22'h0, w, !w}, {22'h0, o_ext_rd_n, o_ext_wr_n});
                if (w) chk("ext_wdata", {16'h0, d}, {16'h0, o_ext_wdata});
            end else begin
                chk("ext_strobes", 24'h3, {22'h0, o_ext_rd_n, o_ext_wr_n});
            end
            @(negedge i_sys_clk);
        end
        if (k == 8) begin
            n_fail++;
            $display("BAD xfer_done expected 1 seen 0");
            close_out();
        end
        chk("xfer_busy", 24'h0, {23'h0, o_xfer_busy});
        chk("bus_oe_seen", {23'h0, oe_exp}, {23'h0, oe});
        if (!w) chk("xfer_rdata", {16'h0, e}, {16'h0, o_xfer_rdata});
    endtask

    initial begin
        n_fail = 0;
        num_checks = 0;
        {i_sfr_wr, i_sfr_rd, i_status_bit_wr, i_status_bit_val, i_flags_wr, i_carry_bit} = '0;
        {i_aux_carry, i_signed_range_flag, i_math_wr, i_aux_wr, i_data_pointer_inc} = '0;
        {i_stack_push, i_stack_pop, i_xfer_req, i_xfer_write, i_status_bit_sel} = '0;
        {i_sfr_addr, i_sfr_wdata, i_math_wdata, i_aux_wdata, i_xfer_wdata} = '0;
        i_sfr_direct = 1'b1;
        i_rstn = 1'b0;
        repeat (3) @(negedge i_sys_clk);
        i_rstn = 1'b1;
        chk("stack_addr", 24'h7, {13'h0, o_stack_addr});
        chk("cfg_outputs", 24'h0, {22'h0, o_wide_stack_enable, o_onchip_ext_ram_enable});
        rd(8'h87, 8'h00);
        rd(8'haf, 8'h00);
        rd(8'hd0, 8'h00);
        rd(8'h81, 8'h07);
        $display("test reset values done");
        wr(8'h87, 8'h02);
        chk("sleep", 24'h1, {23'h0, o_sleep_enable});
        wr(8'hd0, 8'h18);
        chk("reg_bank", 24'h3, {22'h0, o_reg_bank});
        wr(8'he0, 8'h01);
        rd(8'hd0, 8'h19);
        wr(8'haf, 8'hff);
        rd(8'haf, 8'h81);
        chk("cfg_outputs", 24'h3, {22'h0, o_wide_stack_enable, o_onchip_ext_ram_enable});
        i_sfr_direct = 1'b0;
        wr(8'h87, 8'h00);
        i_sfr_direct = 1'b1;
        chk("sleep", 24'h1, {23'h0, o_sleep_enable});
        rd(8'h7f, 8'h00);
        chk("sfr_hit", 24'h0, {23'h0, o_sfr_hit});
        wr(8'h87, 8'hf1);
        rd(8'h87, 8'hf1);
        chk("sfr_hit", 24'h1, {23'h0, o_sfr_hit});
        chk("power_bits", 24'h3d, {18'h0, o_baud_double, o_serial_periph_wake_enable,
            o_ext_int_zero_wake_enable, o_latch_strobe_disable, o_sleep_enable,
            o_core_halt_enable});
        i_math_wdata = 8'h03;
        pulse(i_math_wr);
        chk("math_result", 24'h03, {16'h0, o_math_result});
        i_aux_wdata = 8'h5c;
        pulse(i_aux_wr);
        chk("aux_math", 24'h5c, {16'h0, o_aux_math});
        rd(8'hf0, 8'h5c);
        {i_carry_bit, i_aux_carry, i_signed_range_flag} = 3'b101;
        pulse(i_flags_wr);
        rd(8'hd0, 8'h9c);
        i_status_bit_sel = 3'h5;
        i_status_bit_val = 1'b1;
        pulse(i_status_bit_wr);
        rd(8'hd0, 8'hbc);
        $display("test register access done");
        wr(8'h84, 8'h00);
        wr(8'h83, 8'hff);
        wr(8'h82, 8'hff);
        pulse(i_data_pointer_inc);
        chk("data_pointer", 24'h010000, o_data_pointer);
        wr(8'h81, 8'hff);
        wr(8'hb7, 8'h00);
        push(11'h100);
        chk("stack_in_onchip_ext_ram", 24'h1, {23'h0, o_stack_in_onchip_ext_ram});
        rd(8'hb7, 8'h01);
        wr(8'haf, 8'h00);
        wr(8'h81, 8'hff);
        push(11'h000);
        rd(8'hb7, 8'h00);
        pulse(i_stack_pop);
        chk("stack_addr", 24'h0ff, {13'h0, o_stack_addr});
        $display("test pointers done");
        wr(8'haf, 8'h01);
        wr(8'h84, 8'h00);
        wr(8'h83, 8'h07);
        wr(8'h82, 8'hff);
        xfer(1'b1, 8'h3c, 8'h00, 1'b0, 24'h0007ff);
        xfer(1'b0, 8'h00, 8'h3c, 1'b0, 24'h0007ff);
        wr(8'h83, 8'h08);
        wr(8'h82, 8'h00);
        xfer(1'b0, 8'h00, 8'h5a, 1'b1, 24'h000800);
        wr(8'haf, 8'h00);
        wr(8'h83, 8'h00);
        xfer(1'b0, 8'h00, 8'h5a, 1'b1, 24'h000000);
        xfer(1'b1, 8'ha7, 8'h00, 1'b1, 24'h000000);
        $display("test data moves done");
        close_out();
    end
endmodule
